// ===== logic/sfl_pkg.sv
/*
 * Constants shared by the serial flash link front end: register map,
 * field positions, reset values, command codes and timing counts.
 * Assumes a 50 MHz system clock.
 */
`default_nettype none
package sfl_pkg;
   // System clock rate
   localparam int CLK_HZ = 50000000;
   // Timing, in the unit printed
   localparam int SOFT_RESET_NS = 10000;
   localparam int HW_RESET_NS = 1000;
   // Least times round up to whole cycles
   localparam int SOFT_RESET_CYC = (SOFT_RESET_NS * (CLK_HZ / 1000000)
      + 999) / 1000;
   localparam int HW_RESET_CYC = (HW_RESET_NS * (CLK_HZ / 1000000)
      + 999) / 1000;
   // Register byte offsets
   localparam logic [7:0] REG_CFG = 8'h00;
   localparam logic [7:0] REG_TXDATA = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ADDR = 8'h0C;
   // Configuration field positions and reset value
   localparam int CFG_PAUSE_OR_CLEAR_SELECT = 0;
   localparam int CFG_FOUR_LINE_ENABLE_BIT = 1;
   localparam logic [1:0] CFG_RESET = 2'h0;
   localparam logic [7:0] TXDATA_RESET = 8'h00;
   // Status field positions
   localparam int ST_FOUR_WIRE = 0;
   localparam int ST_PAUSED = 1;
   localparam int ST_SOFT_BUSY = 2;
   localparam int ST_HW_RESET = 3;
   localparam int ST_CLK_MODE3 = 4;
   localparam int ST_RESET_ARMED = 5;
   localparam int ST_LAST_CMD_LSB = 8;
   localparam int ST_CYCLE_LSB = 16;
   // Command codes
   localparam logic [7:0] CMD_ENTER_FOUR_WIRE = 8'h38;
   localparam logic [7:0] CMD_EXIT_FOUR_WIRE = 8'hFF;
   localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
   localparam logic [7:0] CMD_RESET = 8'h99;
   localparam logic [7:0] CMD_READ_DUAL_OUT = 8'h3B;
   localparam logic [7:0] CMD_READ_DUAL_IO = 8'hBB;
   localparam logic [7:0] CMD_READ_QUAD_OUT = 8'h6B;
   localparam logic [7:0] CMD_READ_QUAD_IO = 8'hEB;
   localparam logic [7:0] CMD_READ_WORD_QUAD_IO = 8'hE7;
   localparam logic [7:0] CMD_READ_OCTAL_QUAD_IO = 8'hE3;
   // Address plus mode bits shifted in by I/O reads
   localparam logic [5:0] IO_ADDR_BITS = 6'd32;
   // Transfer widths
   localparam logic [2:0] W_SINGLE = 3'd1;
   localparam logic [2:0] W_DUAL = 3'd2;
   localparam logic [2:0] W_QUAD = 3'd4;
   // Link phases, Gray coded along the usual path
   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_ADDR = 2'b01,
      PH_DATA = 2'b11,
      PH_IGNORE = 2'b10
   } sfl_phase_t;
endpackage : sfl_pkg
`default_nettype wire

// ===== logic/sfl_link.sv
/*
 * Host link front end of a serial NOR flash: clock modes, bit edges,
 * dual and quad widths, four-wire command mode, pause, command reset
 * and the shared pause/reset pin, with an AHB-Lite register slave.
 * Assumes all link pins are asynchronous to CLK_I and that the link
 * clock runs well below a quarter of CLK_I.
 */
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sfl_link
   import sfl_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   // AHB-Lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // Link pins
   input wire logic SELECT_N_I,
   input wire logic LINK_CLK_I,
   input wire logic DATA_LINE_0_I,
   input wire logic DATA_LINE_1_I,
   input wire logic DATA_LINE_2_I,
   input wire logic DATA_LINE_3_I,
   output logic DATA_LINE_0_O,
   output logic DATA_LINE_1_O,
   output logic DATA_LINE_2_O,
   output logic DATA_LINE_3_O,
   output logic DATA_LINE_0_OE_O,
   output logic DATA_LINE_1_OE_O,
   output logic DATA_LINE_2_OE_O,
   output logic DATA_LINE_3_OE_O,
   // Toward the rest of the device
   output logic CMD_VALID_O,
   output logic [7:0] CMD_CODE_O,
   output logic CORE_RESET_O,
   output logic ABORT_O,
   output logic BUSY_O,
   output logic FOUR_WIRE_MODE_O
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic clk_d_reg;
   logic sel_d_reg;
   logic [5:0] pin_raw;
   logic sel_n;
   logic lclk;
   logic [3:0] din;
   logic clk_rise;
   logic clk_fall;
   logic sel_fall;
   logic [1:0] cfg_reg;
   logic [7:0] tx_data_reg;
   logic qe;
   logic pin_is_reset;
   logic paused_reg;
   logic paused_next;
   logic hold_en;
   logic [5:0] hw_cnt_reg;
   logic hw_active_reg;
   logic [8:0] soft_cnt_reg;
   logic soft_busy;
   logic soft_start;
   logic power_on;
   logic four_wire_reg;
   logic armed_reg;
   logic mode3_reg;
   logic [7:0] cyc_cnt_reg;
   sfl_phase_t phase_reg;
   logic [2:0] width_reg;
   logic [7:0] shift_reg;
   logic [5:0] bit_cnt_reg;
   logic [23:0] addr_reg;
   logic [7:0] out_sh_reg;
   logic [3:0] out_cnt_reg;
   logic [3:0] out_reg;
   logic [3:0] oe_reg;
   logic [7:0] last_cmd_reg;
   logic cmd_valid_reg;
   logic core_reset_reg;
   logic abort_reg;
   logic [7:0] new_byte;
   logic [5:0] bits_after;
   logic byte_done;
   logic [31:0] status_word;
   logic ph_write_reg;
   logic ph_read_reg;
   logic [7:0] ph_addr_reg;
   logic [31:0] rdata_reg;
   logic ahb_go;
   logic edge_ok;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two flops per input
   assign pin_raw = {SELECT_N_I, LINK_CLK_I, DATA_LINE_3_I, DATA_LINE_2_I,
                     DATA_LINE_1_I, DATA_LINE_0_I};
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_sync
         always_ff @(posedge CLK_I) begin
            if (RST_I) begin
               sync1_reg[g] <= 1'b1;
               sync2_reg[g] <= 1'b1;
            end else if (CE_I) begin
               sync1_reg[g] <= pin_raw[g];
               sync2_reg[g] <= sync1_reg[g];
            end
         end
      end
   endgenerate
   assign sel_n = sync2_reg[5];
   assign lclk = sync2_reg[4];
   assign din = sync2_reg[3:0];

   // Edge finders on the synchronised clock and select
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         // Match the synchroniser preset so no false edge follows reset
         clk_d_reg <= 1'b1;
         sel_d_reg <= 1'b1;
      end else if (CE_I) begin
         clk_d_reg <= lclk;
         sel_d_reg <= sel_n;
      end
   end
   assign clk_rise = lclk & ~clk_d_reg;
   assign clk_fall = ~lclk & clk_d_reg;
   assign sel_fall = ~sel_n & sel_d_reg;

   ////////////////////////////////////////////////////////////////////////
   // Shared pin function and pause
   assign qe = cfg_reg[CFG_FOUR_LINE_ENABLE_BIT];
   assign pin_is_reset = cfg_reg[CFG_PAUSE_OR_CLEAR_SELECT] & ~qe;
   // Pause only when selected, pin is pause, not quad wide
   assign hold_en = ~cfg_reg[CFG_PAUSE_OR_CLEAR_SELECT] & ~qe & ~sel_n
                    & ~four_wire_reg & (width_reg != W_QUAD);
   // Pin level acts only with the clock low: right away or at next fall
   always_comb begin
      paused_next = paused_reg;
      if (sel_n || !hold_en) begin
         paused_next = 1'b0;
      end else if (!lclk) begin
         paused_next = ~din[3];
      end
   end
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         paused_reg <= 1'b0;
      end else if (CE_I) begin
         paused_reg <= paused_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hardware reset pin: low for the full time fires, blocks while low
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         hw_cnt_reg <= 6'd0;
         hw_active_reg <= 1'b0;
         abort_reg <= 1'b0;
      end else if (CE_I) begin
         abort_reg <= 1'b0;
         if (!pin_is_reset || din[3]) begin
            hw_cnt_reg <= 6'd0;
            hw_active_reg <= 1'b0;
         end else if (hw_cnt_reg != 6'(HW_RESET_CYC)) begin
            hw_cnt_reg <= hw_cnt_reg + 6'd1;
         end else if (!hw_active_reg) begin
            hw_active_reg <= 1'b1;
            abort_reg <= 1'b1;
         end
      end
   end

   // Command reset busy period
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         soft_cnt_reg <= 9'd0;
      end else if (CE_I) begin
         if (hw_active_reg) begin
            soft_cnt_reg <= 9'd0;
         end else if (soft_start) begin
            soft_cnt_reg <= 9'(SOFT_RESET_CYC);
         end else if (soft_cnt_reg != 9'd0) begin
            soft_cnt_reg <= soft_cnt_reg - 9'd1;
         end
      end
   end
   assign soft_busy = soft_cnt_reg != 9'd0;
   // Return to power-on state at hardware fire or end of busy period
   assign power_on = (abort_reg) |
                     (soft_cnt_reg == 9'd1);

   // Power-on request toward the core
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         core_reset_reg <= 1'b0;
      end else if (CE_I) begin
         core_reset_reg <= power_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Incoming byte assembly
   assign new_byte = four_wire_reg ? {shift_reg[3:0], din}
                                   : {shift_reg[6:0], din[0]};
   assign bits_after = bit_cnt_reg + 6'(width_reg);
   assign byte_done = bits_after == 6'd8;
   // Clock edges count only while selected, awake and not in reset
   assign edge_ok = ~sel_n & ~paused_reg & ~hw_active_reg;

   // Command decode on the last capture edge of the instruction
   assign soft_start = CE_I & edge_ok & clk_rise & (phase_reg == PH_CMD)
                       & byte_done & ~soft_busy & armed_reg
                       & (new_byte == CMD_RESET);

   // Link state: phase, width, shifters, mode
   always_ff @(posedge CLK_I) begin
      if (RST_I || (power_on && CE_I)) begin
         four_wire_reg <= 1'b0;
         armed_reg <= 1'b0;
         phase_reg <= PH_CMD;
         width_reg <= W_SINGLE;
         bit_cnt_reg <= 6'd0;
         shift_reg <= 8'h00;
         addr_reg <= 24'h000000;
         cmd_valid_reg <= 1'b0;
         last_cmd_reg <= 8'h00;
      end else if (CE_I) begin
         cmd_valid_reg <= 1'b0;
         if (sel_n || hw_active_reg) begin
            // Select high ends the frame and resets phase, width and bit count
            phase_reg <= PH_CMD;
            width_reg <= four_wire_reg ? W_QUAD : W_SINGLE;
            bit_cnt_reg <= 6'd0;
         end else if (edge_ok && clk_rise) begin
            case (phase_reg)
               PH_CMD: begin
                  shift_reg <= new_byte;
                  bit_cnt_reg <= bits_after;
                  if (byte_done && soft_busy) begin
                     phase_reg <= PH_IGNORE;
                  end else if (byte_done) begin
                     bit_cnt_reg <= 6'd0;
                     cmd_valid_reg <= 1'b1;
                     last_cmd_reg <= new_byte;
                     armed_reg <= new_byte == CMD_RESET_ENABLE;
                     phase_reg <= PH_IGNORE;
                     case (new_byte)
                        CMD_ENTER_FOUR_WIRE: begin
                           if (qe) begin
                              four_wire_reg <= 1'b1;
                           end
                        end
                        CMD_EXIT_FOUR_WIRE: begin
                           four_wire_reg <= 1'b0;
                        end
                        CMD_READ_DUAL_OUT: begin
                           width_reg <= four_wire_reg ? W_QUAD : W_DUAL;
                           phase_reg <= PH_DATA;
                        end
                        CMD_READ_DUAL_IO: begin
                           width_reg <= four_wire_reg ? W_QUAD : W_DUAL;
                           phase_reg <= PH_ADDR;
                        end
                        CMD_READ_QUAD_OUT: begin
                           if (qe) begin
                              width_reg <= W_QUAD;
                              phase_reg <= PH_DATA;
                           end
                        end
                        CMD_READ_QUAD_IO, CMD_READ_WORD_QUAD_IO,
                        CMD_READ_OCTAL_QUAD_IO: begin
                           if (qe) begin
                              width_reg <= W_QUAD;
                              phase_reg <= PH_ADDR;
                           end
                        end
                        default: begin
                           phase_reg <= PH_IGNORE;
                        end
                     endcase
                  end
               end
               PH_ADDR: begin
                  // Address and mode bits on the wide lines
                  case (width_reg)
                     W_QUAD: addr_reg <= {addr_reg[19:0], din};
                     default: addr_reg <= {addr_reg[21:0], din[1:0]};
                  endcase
                  bit_cnt_reg <= bits_after;
                  if (bits_after == IO_ADDR_BITS) begin
                     phase_reg <= PH_DATA;
                  end
               end
               PH_DATA: begin
                  phase_reg <= PH_DATA;
               end
               default: begin
                  phase_reg <= PH_IGNORE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outgoing bits, changed on falling link clock edges
   always_ff @(posedge CLK_I) begin
      if (RST_I || (power_on && CE_I)) begin
         out_sh_reg <= 8'h00;
         out_cnt_reg <= 4'd0;
         out_reg <= 4'h0;
         oe_reg <= 4'h0;
      end else if (CE_I) begin
         if (sel_n || hw_active_reg || phase_reg != PH_DATA) begin
            out_cnt_reg <= 4'd0;
            oe_reg <= 4'h0;
         end else if (edge_ok && clk_fall) begin
            if (width_reg == W_QUAD) begin
               oe_reg <= 4'hF;
               if (out_cnt_reg == 4'd0) begin
                  out_reg <= tx_data_reg[7:4];
                  out_sh_reg <= {tx_data_reg[3:0], 4'h0};
                  out_cnt_reg <= 4'd1;
               end else begin
                  out_reg <= out_sh_reg[7:4];
                  out_sh_reg <= {out_sh_reg[3:0], 4'h0};
                  out_cnt_reg <= 4'd0;
               end
            end else begin
               oe_reg <= 4'h3;
               out_reg[3:2] <= 2'b00;
               if (out_cnt_reg == 4'd0) begin
                  out_reg[1:0] <= tx_data_reg[7:6];
                  out_sh_reg <= {tx_data_reg[5:0], 2'b00};
               end else begin
                  out_reg[1:0] <= out_sh_reg[7:6];
                  out_sh_reg <= {out_sh_reg[5:0], 2'b00};
               end
               out_cnt_reg <= (out_cnt_reg == 4'd3) ? 4'd0
                              : out_cnt_reg + 4'd1;
            end
         end
      end
   end
   assign {DATA_LINE_3_O, DATA_LINE_2_O, DATA_LINE_1_O, DATA_LINE_0_O} =
      out_reg;
   // Drivers float while paused
   assign {DATA_LINE_3_OE_O, DATA_LINE_2_OE_O, DATA_LINE_1_OE_O,
           DATA_LINE_0_OE_O} = oe_reg & ~{4{paused_reg}};

   ////////////////////////////////////////////////////////////////////////
   // Clock mode and falling-edge cycle count
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         mode3_reg <= 1'b0;
         cyc_cnt_reg <= 8'h00;
      end else if (CE_I) begin
         if (sel_fall) begin
            mode3_reg <= lclk;
            cyc_cnt_reg <= lclk ? 8'h00 : 8'h01;
         end else if (edge_ok && clk_fall && cyc_cnt_reg != 8'hFF) begin
            cyc_cnt_reg <= cyc_cnt_reg + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states while enabled
   assign ahb_go = HSEL_I & HREADY_I & HTRANS_I[1] & CE_I;
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         ph_write_reg <= 1'b0;
         ph_read_reg <= 1'b0;
         ph_addr_reg <= 8'h00;
      end else if (CE_I) begin
         ph_write_reg <= ahb_go & HWRITE_I;
         ph_read_reg <= ahb_go & ~HWRITE_I;
         ph_addr_reg <= HADDR_I[7:0];
      end
   end

   // Software writable configuration and transmit byte
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         cfg_reg <= CFG_RESET;
         tx_data_reg <= TXDATA_RESET;
      end else if (CE_I && ph_write_reg) begin
         if (ph_addr_reg == REG_CFG) begin
            cfg_reg <= HWDATA_I[1:0];
         end
         if (ph_addr_reg == REG_TXDATA) begin
            tx_data_reg <= HWDATA_I[7:0];
         end
      end
   end

   // Status word
   always_comb begin
      status_word = 32'h00000000;
      status_word[ST_FOUR_WIRE] = four_wire_reg;
      status_word[ST_PAUSED] = paused_reg;
      status_word[ST_SOFT_BUSY] = soft_busy;
      status_word[ST_HW_RESET] = hw_active_reg;
      status_word[ST_CLK_MODE3] = mode3_reg;
      status_word[ST_RESET_ARMED] = armed_reg;
      status_word[ST_LAST_CMD_LSB +: 8] = last_cmd_reg;
      status_word[ST_CYCLE_LSB +: 8] = cyc_cnt_reg;
   end

   // Read data captured at the address phase
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         rdata_reg <= 32'h00000000;
      end else if (CE_I) begin
         rdata_reg <= 32'h00000000;
         if (ahb_go && !HWRITE_I) begin
            case (HADDR_I[7:0])
               REG_CFG: rdata_reg <= {30'h00000000, cfg_reg};
               REG_TXDATA: rdata_reg <= {24'h000000, tx_data_reg};
               REG_STATUS: rdata_reg <= status_word;
               REG_ADDR: rdata_reg <= {8'h00, addr_reg};
               default: rdata_reg <= 32'h00000000;
            endcase
         end
      end
   end

   assign HRDATA_O = rdata_reg;
   assign HREADYOUT_O = CE_I;
   assign HRESP_O = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Core-side outputs
   assign CMD_VALID_O = cmd_valid_reg;
   assign CMD_CODE_O = last_cmd_reg;
   assign CORE_RESET_O = core_reset_reg;
   assign ABORT_O = abort_reg;
   assign BUSY_O = soft_busy | hw_active_reg;
   assign FOUR_WIRE_MODE_O = four_wire_reg;

endmodule : sfl_link
`default_nettype wire

// ===== verif/sfl_link_sva.sv
/* Port checker for sfl_link, attached by bind.
   Assumes one CLK_I domain and a synchronous RST_I. */
`timescale 1ns/100ps
`default_nettype none
module sfl_link_sva (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire logic SELECT_N_I,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   input wire logic DATA_LINE_0_OE_O,
   input wire logic DATA_LINE_1_OE_O,
   input wire logic CMD_VALID_O,
   input wire logic CORE_RESET_O,
   input wire logic ABORT_O,
   input wire logic BUSY_O,
   input wire logic FOUR_WIRE_MODE_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);
   // Select released long enough to pass the synchronisers
   sequence sel_idle_s;
      SELECT_N_I [*5];
   endsequence
   // Busy stays up for a while once raised
   sequence busy_run_s;
      BUSY_O [*8];
   endsequence
   ////////////////////////////////////////////////////////////////////
   // Bus side
   ready_ce_a: assert property (HREADYOUT_O == CE_I)
      else $error("hready does not follow enable");
   resp_okay_a: assert property (!HRESP_O)
      else $error("error response seen");
   // Link side
   cmd_pulse_a: assert property (CMD_VALID_O |=> !CMD_VALID_O)
      else $error("command pulse too long");
   busy_block_a: assert property ($past(BUSY_O) && BUSY_O |-> !CMD_VALID_O)
      else $error("command taken while busy");
   sel_float_a: assert property (sel_idle_s |->
      !(DATA_LINE_0_OE_O || DATA_LINE_1_OE_O))
      else $error("lines driven while deselected");
   reset_serial_a: assert property (CORE_RESET_O |=> !FOUR_WIRE_MODE_O)
      else $error("four-wire mode kept after reset");
   abort_busy_a: assert property (ABORT_O |=> BUSY_O)
      else $error("abort without busy");
   busy_hold_a: assert property ($rose(BUSY_O) |-> busy_run_s)
      else $error("busy dropped early");
   core_pulse_a: assert property (CORE_RESET_O |=> !CORE_RESET_O)
      else $error("core reset pulse too long");
endmodule : sfl_link_sva
bind sfl_link sfl_link_sva chk (.*);
`default_nettype wire

// ===== verif/sfl_host.sv
/* Host model driving select, link clock and data lines.
   Assumes 8 CLK_I cycles per link clock period (160 ns). */
`timescale 1ns/100ps
`default_nettype none
module sfl_host (
   input wire logic clk_i,
   input wire logic [3:0] dout_i,
   input wire logic [3:0] doe_i,
   output logic sel_n_o = 1'b1,
   output logic lclk_o = 1'b0,
   output logic [3:0] din_o
);
   logic idle = 1'b0;
   logic [3:0] drv = 4'hC;
   // Wire level from both drivers
   assign din_o = (doe_i & dout_i) | (~doe_i & drv);
   task automatic half;
      repeat (4) @(posedge clk_i);
   endtask : half
   // Frame: command, n data cycles, optional pause in data
   task automatic frame(input logic [7:0] c, input logic four,
      input int n, input logic p, output logic [7:0] rd,
      output logic [1:0] pz);
      lclk_o <= idle;
      half;
      sel_n_o <= 1'b0;
      half;
      for (int i = 0; i < (four ? 2 : 8); i++) begin
         lclk_o <= 1'b0;
         drv <= four ? c[7:4] : {drv[3:1], c[7]};
         c = four ? {c[3:0], 4'h0} : {c[6:0], 1'b0};
         half;
         lclk_o <= 1'b1;
         half;
      end
      for (int i = 0; i < n; i++) begin
         lclk_o <= 1'b0;
         half;
         if (p && i == 1) begin
            drv[3] <= 1'b0;
            half;
            pz = doe_i[1:0];
            lclk_o <= 1'b1;
            half;
            lclk_o <= 1'b0;
            half;
            drv[3] <= 1'b1;
            half;
         end
         lclk_o <= 1'b1;
         half;
         rd = {rd[5:0], din_o[1:0]};
      end
      lclk_o <= idle;
      half;
      sel_n_o <= 1'b1;
      drv <= {2'b11, ~din_o[1:0]};
      half;
   endtask : frame
endmodule : sfl_host
`default_nettype wire

// ===== verif/tb.sv
/* Self-checking bench for sfl_link with an AHB-Lite master.
   Assumes sfl_host and the bound checker are compiled alongside. */
`timescale 1ns/100ps
`default_nettype none
module tb
   import sfl_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, hw = 1'b0;
   logic [1:0] ht = 2'h0, pz;
   logic [31:0] ha = 32'h0, hd = 32'h0, hr, rd32;
   logic hrdy, sel_n, lclk, cmdv, core, abrt, busy, fw;
   logic [3:0] din, dout, doe;
   logic [7:0] rd, code;
   int fail_count = 0, checks = 0, ncmd = 0, n;
   int nco = 0, nab = 0, nq = 0, c0, a0;
   sfl_link dut (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .HSEL_I(1'b1),
      .HADDR_I(ha), .HTRANS_I(ht), .HWRITE_I(hw), .HSIZE_I(3'h2),
      .HWDATA_I(hd), .HREADY_I(hrdy), .HRDATA_O(hr),
      .HREADYOUT_O(hrdy), .HRESP_O(), .SELECT_N_I(sel_n),
      .LINK_CLK_I(lclk), .DATA_LINE_0_I(din[0]), .DATA_LINE_1_I(din[1]),
      .DATA_LINE_2_I(din[2]), .DATA_LINE_3_I(din[3]),
      .DATA_LINE_0_O(dout[0]), .DATA_LINE_1_O(dout[1]),
      .DATA_LINE_2_O(dout[2]), .DATA_LINE_3_O(dout[3]),
      .DATA_LINE_0_OE_O(doe[0]), .DATA_LINE_1_OE_O(doe[1]),
      .DATA_LINE_2_OE_O(doe[2]), .DATA_LINE_3_OE_O(doe[3]),
      .CMD_VALID_O(cmdv), .CMD_CODE_O(code), .CORE_RESET_O(core),
      .ABORT_O(abrt), .BUSY_O(busy), .FOUR_WIRE_MODE_O(fw));
   sfl_host host (.clk_i(clk), .dout_i(dout), .doe_i(doe),
      .sel_n_o(sel_n), .lclk_o(lclk), .din_o(din));
   // Clock and event counters
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      ncmd <= ncmd + int'(cmdv === 1'b1);
      nco <= nco + int'(core === 1'b1);
      nab <= nab + int'(abrt === 1'b1);
      nq <= nq + int'(doe === 4'hF);
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] v, e);
      checks++;
      if (v !== e) begin
         fail_count++;
         $display("wrong value %s exp %h seen %h", s, e, v);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] r);
      ha <= {24'h0, a};
      hw <= w;
      ht <= 2'h2;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      ht <= 2'h0;
      hd <= wd;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      r = hr;
   endtask : bus
   task automatic t_reset;
      bus(1'b0, REG_STATUS, 32'h0, rd32);
      chk("status", rd32, 32'h0);
      bus(1'b0, REG_CFG, 32'h0, rd32);
      chk("cfg", rd32, 32'h0);
      bus(1'b1, 8'h10, 32'hF, rd32);
      bus(1'b0, 8'h10, 32'h0, rd32);
      chk("unmapped", rd32, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_modes;
      bus(1'b1, REG_TXDATA, 32'hB4, rd32);
      for (int m = 0; m < 2; m++) begin
         host.idle = m[0];
         host.frame(CMD_READ_DUAL_OUT, 1'b0, 4, 1'b0, rd, pz);
         chk("dual data", rd, 8'hB4);
         chk("code", code, CMD_READ_DUAL_OUT);
         bus(1'b0, REG_STATUS, 32'h0, rd32);
         chk("status", rd32, {8'h0, m ? 8'd12 : 8'd13, 8'h3B, 3'h0,
            m[0], 4'h0});
      end
      host.idle = 1'b0;
      $display("test modes done");
   endtask : t_modes
   task automatic t_pause;
      host.frame(CMD_READ_DUAL_OUT, 1'b0, 4, 1'b1, rd, pz);
      chk("pause oe", pz, 2'h0);
      chk("resume data", rd, 8'hB4);
      bus(1'b1, REG_CFG, 32'h2, rd32);
      host.frame(CMD_READ_DUAL_OUT, 1'b0, 4, 1'b1, rd, pz);
      chk("no pause", pz, 2'h3);
      $display("test pause done");
   endtask : t_pause
   task automatic t_four;
      bus(1'b1, REG_CFG, 32'h0, rd32);
      n = nq;
      host.frame(CMD_READ_QUAD_OUT, 1'b0, 2, 1'b0, rd, pz);
      chk("quad refused", nq - n, 32'd0);
      host.frame(CMD_ENTER_FOUR_WIRE, 1'b0, 0, 1'b0, rd, pz);
      chk("no enable", fw, 1'b0);
      bus(1'b1, REG_CFG, 32'h2, rd32);
      n = nq;
      host.frame(CMD_READ_QUAD_OUT, 1'b0, 2, 1'b0, rd, pz);
      chk("quad lines", nq > n, 1'b1);
      host.frame(CMD_ENTER_FOUR_WIRE, 1'b0, 0, 1'b0, rd, pz);
      chk("enter", fw, 1'b1);
      host.frame(CMD_EXIT_FOUR_WIRE, 1'b1, 0, 1'b0, rd, pz);
      chk("exit", fw, 1'b0);
      host.frame(CMD_ENTER_FOUR_WIRE, 1'b0, 0, 1'b0, rd, pz);
      host.frame(CMD_RESET_ENABLE, 1'b1, 0, 1'b0, rd, pz);
      c0 = nco;
      a0 = nab;
      host.frame(CMD_RESET, 1'b1, 0, 1'b0, rd, pz);
      chk("busy", busy, 1'b1);
      n = ncmd;
      host.frame(CMD_EXIT_FOUR_WIRE, 1'b1, 0, 1'b0, rd, pz);
      chk("rejected", ncmd, n);
      for (int i = 0; i < 600 && nco == c0; i++) @(posedge clk);
      chk("soft reset", nco - c0, 32'd1);
      chk("no abort", nab - a0, 32'd0);
      chk("serial after", fw, 1'b0);
      $display("test four-wire done");
   endtask : t_four
   task automatic t_hw;
      bus(1'b1, REG_CFG, 32'h1, rd32);
      c0 = nco;
      a0 = nab;
      host.drv[3] <= 1'b0;
      repeat (20) @(posedge clk);
      host.drv[3] <= 1'b1;
      repeat (10) @(posedge clk);
      chk("short pulse", nco - c0 + nab - a0, 32'd0);
      host.drv[3] <= 1'b0;
      repeat (60) @(posedge clk);
      chk("busy low", busy, 1'b1);
      n = ncmd;
      host.frame(CMD_RESET_ENABLE, 1'b0, 0, 1'b0, rd, pz);
      chk("blocked", ncmd, n);
      chk("hw abort", nab - a0, 32'd1);
      chk("hw reset", nco - c0, 32'd1);
      $display("test pin reset done");
   endtask : t_hw
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_reset;
      t_modes;
      t_pause;
      t_four;
      t_hw;
      report_and_stop;
   end
   // Watchdog
   initial begin
      #300000;
      fail_count++;
      report_and_stop;
   end
endmodule : tb
`default_nettype wire
